// >>> urxdm_pkg.sv
// constants for the receive dma / modem status host block, plus its
// two-stage input synchroniser.
// assumes a single pclk domain and an apb master on the register side.
`timescale 1ns/1ps
`default_nettype none

package urxdm_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int LEVEL_W = 5;

  // register byte addresses
  localparam logic [ADDR_W-1:0] OFS_RX_HOLD = 12'h000;
  localparam logic [ADDR_W-1:0] OFS_INT_EN = 12'h004;
  localparam logic [ADDR_W-1:0] OFS_FIFO_CTRL = 12'h008;
  localparam logic [ADDR_W-1:0] OFS_MODEM_CTRL = 12'h010;
  localparam logic [ADDR_W-1:0] OFS_MODEM_STAT = 12'h018;
  localparam logic [ADDR_W-1:0] OFS_DMA_STAT = 12'h01c;

  // field positions
  localparam int IE_MSI_BIT = 3;
  localparam int FCR_EN_BIT = 0;
  localparam int FCR_DMA_BIT = 3;
  localparam int MCR_RTS_BIT = 1;
  localparam int MCR_LOOP_BIT = 4;
  localparam int MSR_CALL_LINE_RISE_FLAG_BIT = 2;
  localparam int MSR_RI_BIT = 6;
  localparam int DST_REQ_BIT = 0;
  localparam int DST_MODE_BIT = 1;
  localparam int DST_LEVEL_LSB = 8;

  // reset values and the empty fifo level
  localparam logic [7:0] INT_EN_RST = 8'h00;
  localparam logic [7:0] FIFO_CTRL_RST = 8'h00;
  localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
  localparam logic [LEVEL_W-1:0] LEVEL_EMPTY = 5'h00;

  typedef enum logic [1:0] {
    DMA_IDLE,
    DMA_ACTIVE
  } urxdm_dma_state_t;
endpackage

// two flip-flop level synchroniser; stage one feeds stage two only
module urxdm_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] stage1_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= RST_VAL;
      sync_out <= RST_VAL;
    end else begin
      stage1_reg <= async_in;
      sync_out <= stage1_reg;
    end
  end
endmodule // urxdm_sync2

`default_nettype wire

// >>> urxdm_top.sv
// register side of the serial controller: host reads, call line status,
// request-to-send, and receive dma request signalling.
// assumes an apb master on pclk and a receive fifo outside this block that
// reports its level, trigger and time-out and pops on rx_pop.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - selected read strobe drives addressed register contents onto data bus
// - master reset clears registers and sets outputs to reset levels
// - modem status bit 6 shows present incoming-call line state
// - call line rise sets status bit 2; status read clears it
// - enabled modem status interrupt raised on call line rise
// - rts active from control bit; inactive on reset, loop, cleared bit
// - rts level never affects transmit or receive operation
// - in fifo mode, fifo control bit 3 picks receive dma mode
// - fifos off forces mode 0; mode 1 drains fifo continuously
// - mode 0: request low while any character held, else high
// - mode 1: low at trigger or time-out, high when empty
module urxdm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [urxdm_pkg::ADDR_W-1:0] paddr,
  input wire logic [urxdm_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic pslverr,
  output logic [urxdm_pkg::DATA_W-1:0] prdata,
  input wire logic incoming_call_line_n,
  input wire logic [urxdm_pkg::LEVEL_W-1:0] rx_level,
  input wire logic rx_trigger_hit,
  input wire logic rx_timeout,
  input wire logic [7:0] rx_data,
  output logic rx_pop,
  output logic fifo_enable_bit,
  output logic loop_mode,
  output logic modem_irq,
  output logic request_to_send_n,
  output logic receive_dma_request_n
);
  import urxdm_pkg::*;

  logic [7:0] int_en_reg;
  logic [7:0] fifo_control_register;
  logic [7:0] modem_control_register;
  logic call_line_rise_flag;
  logic call_line_rise_next;
  logic msr_seen_reg;
  logic call_line_s;
  logic call_line_d_reg;
  logic call_line_rise;
  logic request_to_send_n_reg;
  logic receive_dma_request_n_reg;
  urxdm_dma_state_t dma_state_reg;
  urxdm_dma_state_t dma_state_next;
  logic [DATA_W-1:0] prdata_reg;
  logic [DATA_W-1:0] rd_mux;
  logic addr_ok;
  logic setup_rd;
  logic access;
  logic wr_ok;
  logic rd_done;
  logic rx_empty;
  logic dma_mode1;
  logic rst_seen_reg;

  // the pin is asynchronous to pclk
  urxdm_sync2 #(
    .W(1),
    .RST_VAL(1'b1)
  ) u_call_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in(incoming_call_line_n),
    .sync_out(call_line_s)
  );

  // bus decode
  always_comb begin
    case (paddr)
      OFS_RX_HOLD,
      OFS_INT_EN,
      OFS_FIFO_CTRL,
      OFS_MODEM_CTRL,
      OFS_MODEM_STAT,
      OFS_DMA_STAT: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign access = psel && penable;
  assign setup_rd = psel && !penable && !pwrite;
  assign wr_ok = access && pwrite && addr_ok && pstrb[0];
  assign rd_done = access && !pwrite && addr_ok;
  // zero wait states: read data is captured in the setup cycle
  assign pready = 1'b1;
  assign pslverr = access && !addr_ok;
  assign prdata = prdata_reg;

  // read mux; a read strobe with select returns the addressed register
  always_comb begin
    rd_mux = '0;
    case (paddr)
      OFS_RX_HOLD: rd_mux[7:0] = rx_data;
      OFS_INT_EN: rd_mux[7:0] = int_en_reg;
      OFS_FIFO_CTRL: rd_mux[7:0] = fifo_control_register;
      OFS_MODEM_CTRL: rd_mux[7:0] = modem_control_register;
      OFS_MODEM_STAT: begin
        rd_mux[MSR_RI_BIT] = !call_line_s;
        rd_mux[MSR_CALL_LINE_RISE_FLAG_BIT] = call_line_rise_flag;
      end
      OFS_DMA_STAT: begin
        rd_mux[DST_REQ_BIT] = receive_dma_request_n_reg;
        rd_mux[DST_MODE_BIT] = dma_mode1;
        rd_mux[DST_LEVEL_LSB +: LEVEL_W] = rx_level;
      end
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= '0;
    end else if (setup_rd) begin
      prdata_reg <= rd_mux;
    end
  end

  // one pop per completed read of the holding register
  assign rx_pop = rd_done && (paddr == OFS_RX_HOLD);

  // writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_reg <= INT_EN_RST;
    end else if (wr_ok && paddr == OFS_INT_EN) begin
      int_en_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_control_register <= FIFO_CTRL_RST;
    end else if (wr_ok && paddr == OFS_FIFO_CTRL) begin
      fifo_control_register <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      modem_control_register <= MODEM_CTRL_RST;
    end else if (wr_ok && paddr == OFS_MODEM_CTRL) begin
      modem_control_register <= pwdata[7:0];
    end
  end

  assign fifo_enable_bit = fifo_control_register[FCR_EN_BIT];
  assign loop_mode = modem_control_register[MCR_LOOP_BIT];

  // call line rise detection, on the synchronised level only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_line_d_reg <= 1'b1;
    end else begin
      call_line_d_reg <= call_line_s;
    end
  end

  assign call_line_rise = call_line_s && !call_line_d_reg;

  // remember whether the captured status read saw the flag set, so an
  // event after the capture is not wiped by the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_seen_reg <= 1'b0;
    end else if (setup_rd) begin
      msr_seen_reg <= (paddr == OFS_MODEM_STAT) && call_line_rise_flag;
    end
  end

  always_comb begin
    call_line_rise_next = call_line_rise_flag;
    if (rd_done && paddr == OFS_MODEM_STAT && msr_seen_reg) begin
      call_line_rise_next = 1'b0;
    end
    if (call_line_rise) begin
      call_line_rise_next = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      call_line_rise_flag <= 1'b0;
    end else begin
      call_line_rise_flag <= call_line_rise_next;
    end
  end

  // level request, held until the status read clears the flag
  assign modem_irq = call_line_rise_flag && int_en_reg[IE_MSI_BIT];

  // rts: pure output, feeds nothing else in the block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      request_to_send_n_reg <= 1'b1;
    end else begin
      request_to_send_n_reg <= !(modem_control_register[MCR_RTS_BIT] &&
                                 !modem_control_register[MCR_LOOP_BIT]);
    end
  end

  assign request_to_send_n = request_to_send_n_reg;

  // receive dma request
  assign rx_empty = (rx_level == LEVEL_EMPTY);
  // mode 1 needs fifos on; otherwise mode 0 regardless of the select bit
  assign dma_mode1 = fifo_control_register[FCR_EN_BIT] &&
                     fifo_control_register[FCR_DMA_BIT];

  always_comb begin
    dma_state_next = dma_state_reg;
    case (dma_state_reg)
      DMA_IDLE: begin
        if (!rx_empty && !dma_mode1) begin
          dma_state_next = DMA_ACTIVE;
        end else if (!rx_empty && (rx_trigger_hit || rx_timeout)) begin
          dma_state_next = DMA_ACTIVE;
        end
      end
      DMA_ACTIVE: begin
        if (rx_empty) begin
          dma_state_next = DMA_IDLE;
        end
      end
      default: dma_state_next = DMA_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_state_reg <= DMA_IDLE;
    end else begin
      dma_state_reg <= dma_state_next;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      receive_dma_request_n_reg <= 1'b1;
    end else begin
      receive_dma_request_n_reg <= (dma_state_next != DMA_ACTIVE);
    end
  end

  assign receive_dma_request_n = receive_dma_request_n_reg;

  // helper for the reset check only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  a_read_data_path: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_rd && paddr == OFS_MODEM_CTRL
    |=> prdata[7:0] == $past(modem_control_register) && pready)
    else $error("read data does not match addressed register");

  a_reset_levels: assert property (
    @(posedge pclk) disable iff (!presetn)
    !rst_seen_reg |-> request_to_send_n && receive_dma_request_n &&
                      !modem_irq && prdata == '0)
    else $error("outputs not at reset levels after reset");

  a_call_line_state: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup_rd && paddr == OFS_MODEM_STAT
    |=> prdata[MSR_RI_BIT] == !$past(call_line_s))
    else $error("status bit 6 does not show call line");

  a_rise_sets_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    $rose(call_line_s) |=> call_line_rise_flag)
    else $error("call line rise did not set flag");

  a_read_clears_flag: assert property (
    @(posedge pclk) disable iff (!presetn)
    rd_done && paddr == OFS_MODEM_STAT && msr_seen_reg && !call_line_rise
    |=> !call_line_rise_flag)
    else $error("status read did not clear flag");

  a_irq_on_rise: assert property (
    @(posedge pclk) disable iff (!presetn)
    call_line_rise && int_en_reg[IE_MSI_BIT] && !wr_ok
    |=> modem_irq)
    else $error("enabled call line rise raised no interrupt");

  a_rts_follows_bit: assert property (
    @(posedge pclk) disable iff (!presetn)
    wr_ok && paddr == OFS_MODEM_CTRL
    |=> ##1 request_to_send_n ==
        !($past(pwdata[MCR_RTS_BIT], 2) && !$past(pwdata[MCR_LOOP_BIT], 2)))
    else $error("rts level does not follow control write");

  a_pop_on_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_pop |-> access && !pwrite && paddr == OFS_RX_HOLD && !$past(rx_pop))
    else $error("pop without a single holding register read");

  a_mode0_active: assert property (
    @(posedge pclk) disable iff (!presetn)
    !dma_mode1 && !rx_empty |=> !receive_dma_request_n)
    else $error("mode 0 request not active with data held");

  a_fifo_off_mode0: assert property (
    @(posedge pclk) disable iff (!presetn)
    !fifo_control_register[FCR_EN_BIT] && !rx_empty |=> !receive_dma_request_n)
    else $error("fifos off did not use mode 0");

  a_mode1_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    dma_mode1 && receive_dma_request_n && !rx_empty &&
    !rx_trigger_hit && !rx_timeout |=> receive_dma_request_n)
    else $error("mode 1 request active before trigger");

  a_mode1_trigger: assert property (
    @(posedge pclk) disable iff (!presetn)
    dma_mode1 && !rx_empty && (rx_trigger_hit || rx_timeout)
    |=> !receive_dma_request_n)
    else $error("mode 1 request not active at trigger");

  a_empty_idle: assert property (
    @(posedge pclk) disable iff (!presetn)
    rx_empty |=> receive_dma_request_n)
    else $error("request active with no characters");
endmodule // urxdm_top

`default_nettype wire

// >>> urxdm_host.sv
// host model: apb master on the register side of the block.
// assumes pready and pslverr answer in the access phase on pclk.
`timescale 1ns/1ps
`default_nettype none
module urxdm_host (
  input wire logic pclk,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [urxdm_pkg::DATA_W-1:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [urxdm_pkg::ADDR_W-1:0] paddr,
  output logic [urxdm_pkg::DATA_W-1:0] pwdata,
  output logic [3:0] pstrb
);
  import urxdm_pkg::*;
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    pstrb = 4'h0;
  end
  // unbounded wait: a missing pready is left to the bench watchdog
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
      input logic [7:0] d, output logic [DATA_W-1:0] rd,
      output logic err);
    @(posedge pclk);
    psel <= 1'b1; // select only for a transfer
    pwrite <= w; // one read strobe kind only
    paddr <= a;
    pwdata <= {24'h000000, d};
    pstrb <= 4'hf;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // urxdm_host
`default_nettype wire

// >>> test_uart_host_read_modem_rx_dma.sv
// bench: host model, fifo model and request model around urxdm_top.
// assumes the fifo pops on rx_pop and everything runs on pclk.
`timescale 1ns/1ps
`default_nettype none
module test_uart_host_read_modem_rx_dma;
  import urxdm_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0] pstrb;
  logic call_n, trig, tmo, rx_pop, fen, loopm, irq, rts_n, req_n;
  logic [LEVEL_W-1:0] lvl;
  logic [7:0] rx_data, fcr_m, e;
  logic [31:0] seed;
  logic [7:0] mcr_tab [5] = '{8'h12, 8'h02, 8'h10, 8'h00, 8'h02};
  logic [7:0] fcr_tab [4] = '{8'h00, 8'h01, 8'h08, 8'h09};
  int n_mismatch, num_checks, m_req, cnt;

  urxdm_host host (.pclk(pclk), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
  urxdm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .incoming_call_line_n(call_n), .rx_level(lvl),
    .rx_trigger_hit(trig), .rx_timeout(tmo), .rx_data(rx_data),
    .rx_pop(rx_pop), .fifo_enable_bit(fen), .loop_mode(loopm),
    .modem_irq(irq), .request_to_send_n(rts_n),
    .receive_dma_request_n(req_n));

  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk1(input logic g, input logic x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: bit %b exp %b", $time, g, x);
    end
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] x);
    num_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("wrong value at %0t: byte %h exp %h", $time, g, x);
    end
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // outputs are looked at on the falling edge, away from updates
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, rd, err);
    if (a == OFS_FIFO_CTRL) fcr_m <= d;
  endtask

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] x);
    host.xfer(1'b0, a, 8'h00, rd, err);
    chk8(rd[7:0], x);
  endtask

  // fifo model: pop takes the head, a new random head follows
  always @(posedge pclk) if (rx_pop === 1'b1) begin
    lvl <= lvl - 1'b1;
    rx_data <= 8'(xs());
  end

  // request model; nonblocking fcr copy updates on the same edge as the register write
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) m_req <= 1;
    else if (lvl == 0) m_req <= 1;
    else if (!(fcr_m[0] && fcr_m[3])) m_req <= 0;
    else if (trig || tmo) m_req <= 0;
  end
  always @(negedge pclk) if (presetn) chk1(req_n, m_req[0]);

  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    final_report;
  end

  initial begin
    seed = 32'h00014811;
    presetn = 1'b0;
    call_n = 1'b1;
    trig = 1'b0;
    tmo = 1'b0;
    lvl = '0;
    rx_data = 8'h3c;
    fcr_m = 8'h00;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_INT_EN, INT_EN_RST);
    rdchk(OFS_FIFO_CTRL, FIFO_CTRL_RST);
    rdchk(OFS_MODEM_CTRL, MODEM_CTRL_RST);
    settle(0);
    chk1(rts_n, 1'b1);
    chk1(irq, 1'b0);
    host.xfer(1'b0, 12'h00c, 8'h00, rd, err);
    chk1(err, 1'b1);
    chk8(rd[7:0], 8'h00);
    for (int i = 0; i < 5; i++) begin
      wr(OFS_MODEM_CTRL, mcr_tab[i]);
      settle(2);
      chk1(rts_n, !(mcr_tab[i][1] && !mcr_tab[i][4]));
      chk1(loopm, mcr_tab[i][4]);
    end
    rdchk(OFS_MODEM_CTRL, 8'h02);
    for (int en = 1; en >= 0; en--) begin
      wr(OFS_INT_EN, en[0] ? 8'h08 : 8'h00);
      call_n <= 1'b0;
      settle(4);
      rdchk(OFS_MODEM_STAT, 8'h40);
      call_n <= 1'b1;
      settle(4);
      chk1(irq, en[0]);
      rdchk(OFS_MODEM_STAT, 8'h04);
      settle(1);
      chk1(irq, 1'b0);
      rdchk(OFS_MODEM_STAT, 8'h00);
    end
    // rts stays active through all dma traffic below
    for (int f = 0; f < 4; f++) begin
      wr(OFS_FIFO_CTRL, fcr_tab[f]);
      cnt = int'(xs() % 6) + 2;
      lvl <= LEVEL_W'(cnt);
      settle(3);
      @(posedge pclk);
      if (xs() & 1) trig <= 1'b1;
      else tmo <= 1'b1;
      @(posedge pclk);
      trig <= 1'b0;
      tmo <= 1'b0;
      settle(2);
      host.xfer(1'b0, OFS_DMA_STAT, 8'h00, rd, err);
      chk1(rd[DST_MODE_BIT], fcr_tab[f][0] & fcr_tab[f][3]);
      chk1(fen, fcr_tab[f][0]);
      chk8(8'(rd[DST_LEVEL_LSB +: LEVEL_W]), 8'(cnt));
      for (int k = 0; k < cnt; k++) begin
        @(negedge pclk);
        e = rx_data;
        rdchk(OFS_RX_HOLD, e);
      end
      settle(2);
      chk8(8'(lvl), 8'h00);
    end
    chk1(rts_n, 1'b0);
    @(posedge pclk);
    presetn <= 1'b0;
    fcr_m <= 8'h00;
    settle(1);
    chk1(rts_n, 1'b1);
    chk1(req_n, 1'b1);
    @(posedge pclk);
    presetn <= 1'b1;
    rdchk(OFS_MODEM_CTRL, MODEM_CTRL_RST);
    rdchk(OFS_FIFO_CTRL, FIFO_CTRL_RST);
    final_report;
  end
endmodule // test_uart_host_read_modem_rx_dma
`default_nettype wire
